//--- pmbst_pkg.sv
// Purpose: Shared constants for the power module status and telemetry register bank.
// Assumes: Command codes are 8 bits and every data word is 16 bits, byte values in the low byte.
// Notes: Status flags live in one 40-bit vector, five bytes, in the order listed below.
package pmbst_pkg;
   // Command codes of the registers in this bank.
   localparam logic [7:0] CMD_STATUS_SUMMARY = 8'h79;
   localparam logic [7:0] CMD_OUTPUT_VOLTAGE_STATUS = 8'h7a;
   localparam logic [7:0] CMD_OUTPUT_CURRENT_STATUS = 8'h7b;
   localparam logic [7:0] CMD_INPUT_STATUS = 8'h7c;
   localparam logic [7:0] CMD_TEMPERATURE_STATUS = 8'h7d;
   localparam logic [7:0] CMD_COMMUNICATION_STATUS = 8'h7e;
   localparam logic [7:0] CMD_INPUT_VOLTAGE_READING = 8'h88;
   localparam logic [7:0] CMD_OUTPUT_VOLTAGE_READING = 8'h8b;
   localparam logic [7:0] CMD_OUTPUT_CURRENT_READING = 8'h8c;
   localparam logic [7:0] CMD_TEMPERATURE_READING = 8'h8d;
   localparam logic [7:0] CMD_MODULE_TYPE_WORD = 8'hd0;

   // Geometry of the flag vector.
   localparam int unsigned STATUS_BYTES = 5;
   localparam int unsigned FLAG_W = 40;
   localparam int unsigned BYTE_VOUT = 0;
   localparam int unsigned BYTE_IOUT = 1;
   localparam int unsigned BYTE_INPUT = 2;
   localparam int unsigned BYTE_TEMP = 3;
   localparam int unsigned BYTE_CML = 4;

   // Bit positions of the supported flags inside their bytes.
   localparam int unsigned BIT_VOUT_OV_FAULT = 7;
   localparam int unsigned BIT_IOUT_OC_FAULT = 7;
   localparam int unsigned BIT_IOUT_OC_WARN = 5;
   localparam int unsigned BIT_VIN_OV_FAULT = 7;
   localparam int unsigned BIT_VIN_UV_FAULT = 4;
   localparam int unsigned BIT_UNIT_OFF_LOW_VIN = 3;
   localparam int unsigned BIT_OT_FAULT = 7;
   localparam int unsigned BIT_OT_WARN = 6;
   localparam int unsigned BIT_INVALID_CMD = 7;
   localparam int unsigned BIT_INVALID_DATA = 6;
   localparam int unsigned BIT_PEC_FAILED = 5;

   // Supported-bit masks; every other bit is held at zero.
   localparam logic [7:0] MASK_VOUT = 8'h80;
   localparam logic [7:0] MASK_IOUT = 8'ha0;
   localparam logic [7:0] MASK_INPUT = 8'h98;
   localparam logic [7:0] MASK_TEMP = 8'hc0;
   localparam logic [7:0] MASK_CML = 8'he0;

   // Summary word bit positions.
   localparam int unsigned SUM_VOUT = 15;
   localparam int unsigned SUM_IOUT = 14;
   localparam int unsigned SUM_INPUT = 13;
   localparam int unsigned SUM_PWR_NOT_GOOD = 11;
   localparam int unsigned SUM_OUTPUT_OFF = 6;
   localparam int unsigned SUM_VOUT_OV = 5;
   localparam int unsigned SUM_IOUT_OC = 4;
   localparam int unsigned SUM_VIN_UV = 3;
   localparam int unsigned SUM_TEMP = 2;
   localparam int unsigned SUM_CML = 1;

   // Module type word layout and reset values.
   localparam int unsigned TYPE_NAME_LSB = 2;
   localparam int unsigned TYPE_NAME_W = 6;
   localparam int unsigned TYPE_WPE_BIT = 1;
   localparam logic TYPE_WPE_RESET = 1'b1;
   localparam logic [5:0] TYPE_NAME_DEFAULT = 6'h15;
   localparam logic [15:0] WORD_RESET = 16'h0000;
   localparam logic [39:0] FLAGS_RESET = 40'h00_0000_0000;
endpackage

//--- pmbst_flags.sv
// Purpose: Bank of sticky flags, set by hardware and cleared by writing one.
// Assumes: Set and clear vectors are single-cycle terms on core_clk_i.
// Notes: A set arriving with a clear of the same bit wins, so no event is lost.
module pmbst_flags #(
   parameter int unsigned W = 40
) (
   input wire logic core_clk_i,
   input wire logic resetn_i,
   input wire logic [W-1:0] set_i,
   input wire logic [W-1:0] clr_i,
   output logic [W-1:0] flags_o
);
   // All state of this module.
   typedef struct packed {
      logic [W-1:0] flags;
   } pmbst_flags_state_t;

   pmbst_flags_state_t st; // Current state.
   pmbst_flags_state_t next_st; // Next state.

   // Clear first, then set, so a simultaneous set survives.
   always_comb begin
      next_st = st;
      next_st.flags = (st.flags & ~clr_i) | set_i;
   end

   // Flags reset to zero and otherwise hold until cleared.
   always_ff @(posedge core_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         st.flags <= '0;
      end else begin
         st <= next_st;
      end
   end

   assign flags_o = st.flags;
endmodule

//--- pmbst_regs.sv
// Purpose: Status, telemetry and module type registers of the power module command port.
// Assumes: Fault detector levels are asynchronous; commands and readings are on core_clk_i.
// Notes: A read answers one cycle after the command with rsp_valid_o and rsp_data_o.
//
// Overview of operation
// R1 - Output voltage status: only overvoltage fault bit 7.
// R2 - Output current status: fault bit 7, warning bit 5.
// R3 - Input status: OV bit 7, UV 4, off 3.
// R4 - Temperature status: fault bit 7, warning bit 6.
// R5 - Comms status: bad command, bad data, PEC.
// R6 - Four telemetry reads return current measured values.
// R7 - Type word: name in 7:2, high byte and bit 0 reserved zero.
// R8 - Type word bit 1 is writable write protect.
// R9 - Summary word aggregates the detailed status bytes.
// R10 - Unsupported bits zero; supported flags stay latched.
// R11 - Host clears a flag by writing one.
module pmbst_regs #(
   parameter logic [5:0] MODULE_NAME = pmbst_pkg::TYPE_NAME_DEFAULT // Arbitrary value.
) (
   input wire logic core_clk_i,
   input wire logic resetn_i,
   input wire logic cmd_valid_i,
   input wire logic [7:0] cmd_code_i,
   input wire logic cmd_write_i,
   input wire logic [15:0] cmd_wdata_i,
   input wire logic cmd_pec_err_i,
   input wire logic vout_ov_fault_i,
   input wire logic iout_oc_fault_i,
   input wire logic iout_oc_warn_i,
   input wire logic vin_ov_fault_i,
   input wire logic vin_uv_fault_i,
   input wire logic unit_off_low_vin_i,
   input wire logic ot_fault_i,
   input wire logic ot_warn_i,
   input wire logic power_good_i,
   input wire logic output_off_i,
   input wire logic [15:0] vin_meas_i,
   input wire logic [15:0] vout_meas_i,
   input wire logic [15:0] iout_meas_i,
   input wire logic [15:0] temp_meas_i,
   output logic rsp_valid_o,
   output logic [15:0] rsp_data_o,
   output logic write_protect_enable_o
);
   // Number of asynchronous detector levels brought through synchronisers.
   localparam int unsigned NSYNC = 10;

   // All state of this module apart from the sticky flags.
   typedef struct packed {
      logic [NSYNC-1:0] sync1; // First stage, read only by the second.
      logic [NSYNC-1:0] sync2; // Second stage, safe to use.
      logic [15:0] vin; // Latest input voltage reading.
      logic [15:0] vout; // Latest output voltage reading.
      logic [15:0] iout; // Latest output current reading.
      logic [15:0] temp; // Latest temperature reading.
      logic write_protect_enable; // Write protect enable.
      logic rsp_valid; // Read answer strobe.
      logic [15:0] rsp_data; // Read answer word.
   } pmbst_state_t;

   pmbst_state_t st; // Current state.
   pmbst_state_t next_st; // Next state.
   logic [pmbst_pkg::FLAG_W-1:0] flags; // Sticky status flags.
   logic [pmbst_pkg::FLAG_W-1:0] flag_set; // Hardware set terms.
   logic [pmbst_pkg::FLAG_W-1:0] flag_clr; // Host clear terms.
   logic [NSYNC-1:0] raw_det; // Detector levels before synchronising.
   logic [7:0] b_vout; // Visible status bytes.
   logic [7:0] b_iout;
   logic [7:0] b_input;
   logic [7:0] b_temp;
   logic [7:0] b_cml;
   logic [15:0] summary; // Aggregated summary word.
   logic [15:0] type_word; // Module type word as read.

   assign raw_det = {output_off_i, power_good_i, ot_warn_i, ot_fault_i, unit_off_low_vin_i,
                     vin_uv_fault_i, vin_ov_fault_i, iout_oc_warn_i, iout_oc_fault_i,
                     vout_ov_fault_i};

   // Sticky flag storage, one bank for all five status bytes.
   pmbst_flags #(
      .W(pmbst_pkg::FLAG_W)
   ) u_flags (
      .core_clk_i(core_clk_i),
      .resetn_i(resetn_i),
      .set_i(flag_set),
      .clr_i(flag_clr),
      .flags_o(flags)
   );

   // Masking keeps unsupported and reserved positions at zero on every read.
   assign b_vout = flags[8*pmbst_pkg::BYTE_VOUT +: 8] & pmbst_pkg::MASK_VOUT; // [R1] [R10]
   assign b_iout = flags[8*pmbst_pkg::BYTE_IOUT +: 8] & pmbst_pkg::MASK_IOUT; // [R2] [R10]
   assign b_input = flags[8*pmbst_pkg::BYTE_INPUT +: 8] & pmbst_pkg::MASK_INPUT; // [R3] [R10]
   assign b_temp = flags[8*pmbst_pkg::BYTE_TEMP +: 8] & pmbst_pkg::MASK_TEMP; // [R4] [R10]
   assign b_cml = flags[8*pmbst_pkg::BYTE_CML +: 8] & pmbst_pkg::MASK_CML; // [R5] [R10]

   // Summary word; fan, vendor, unknown, busy and none-of-above bits stay zero.
   always_comb begin
      summary = pmbst_pkg::WORD_RESET;
      summary[pmbst_pkg::SUM_VOUT] = |b_vout; // [R9]
      summary[pmbst_pkg::SUM_IOUT] = |b_iout; // [R9]
      summary[pmbst_pkg::SUM_INPUT] = |b_input; // [R9]
      summary[pmbst_pkg::SUM_PWR_NOT_GOOD] = ~st.sync2[8]; // [R9]
      summary[pmbst_pkg::SUM_OUTPUT_OFF] = st.sync2[9]; // [R9]
      summary[pmbst_pkg::SUM_VOUT_OV] = b_vout[pmbst_pkg::BIT_VOUT_OV_FAULT]; // [R9]
      summary[pmbst_pkg::SUM_IOUT_OC] = b_iout[pmbst_pkg::BIT_IOUT_OC_FAULT]; // [R9]
      summary[pmbst_pkg::SUM_VIN_UV] = b_input[pmbst_pkg::BIT_VIN_UV_FAULT]; // [R9]
      summary[pmbst_pkg::SUM_TEMP] = |b_temp; // [R9]
      summary[pmbst_pkg::SUM_CML] = |b_cml; // [R9]
   end

   // Type word: high byte and bit 0 reserved at zero, name fixed, write protect stored.
   always_comb begin
      type_word = pmbst_pkg::WORD_RESET;
      type_word[pmbst_pkg::TYPE_NAME_LSB +: pmbst_pkg::TYPE_NAME_W] = MODULE_NAME; // [R7]
      type_word[pmbst_pkg::TYPE_WPE_BIT] = st.write_protect_enable; // [R8]
   end

   // Command decode, flag set and clear terms, and the next register state.
   always_comb begin
      logic known;
      logic readonly;
      logic wr;
      logic [15:0] legal;
      known = 1'b0;
      readonly = 1'b0;
      wr = 1'b0;
      legal = pmbst_pkg::WORD_RESET;
      next_st = st;
      flag_set = pmbst_pkg::FLAGS_RESET;
      flag_clr = pmbst_pkg::FLAGS_RESET;
      next_st.sync1 = raw_det;
      next_st.sync2 = st.sync1;
      // Readings follow the measurement path every cycle so reads are always current.
      next_st.vin = vin_meas_i; // [R6]
      next_st.vout = vout_meas_i; // [R6]
      next_st.iout = iout_meas_i; // [R6]
      next_st.temp = temp_meas_i; // [R6]
      next_st.rsp_valid = 1'b0;
      // Detector levels set flags every cycle they are present.
      flag_set[8*pmbst_pkg::BYTE_VOUT + pmbst_pkg::BIT_VOUT_OV_FAULT] = st.sync2[0]; // [R1]
      flag_set[8*pmbst_pkg::BYTE_IOUT + pmbst_pkg::BIT_IOUT_OC_FAULT] = st.sync2[1]; // [R2]
      flag_set[8*pmbst_pkg::BYTE_IOUT + pmbst_pkg::BIT_IOUT_OC_WARN] = st.sync2[2]; // [R2]
      flag_set[8*pmbst_pkg::BYTE_INPUT + pmbst_pkg::BIT_VIN_OV_FAULT] = st.sync2[3]; // [R3]
      flag_set[8*pmbst_pkg::BYTE_INPUT + pmbst_pkg::BIT_VIN_UV_FAULT] = st.sync2[4]; // [R3]
      flag_set[8*pmbst_pkg::BYTE_INPUT + pmbst_pkg::BIT_UNIT_OFF_LOW_VIN] = st.sync2[5]; // [R3]
      flag_set[8*pmbst_pkg::BYTE_TEMP + pmbst_pkg::BIT_OT_FAULT] = st.sync2[6]; // [R4]
      flag_set[8*pmbst_pkg::BYTE_TEMP + pmbst_pkg::BIT_OT_WARN] = st.sync2[7]; // [R4]
      if (cmd_valid_i) begin
         if (cmd_pec_err_i) begin
            // A corrupted packet is dropped whole; only the PEC flag records it.
            flag_set[8*pmbst_pkg::BYTE_CML + pmbst_pkg::BIT_PEC_FAILED] = 1'b1; // [R5]
         end else begin
            wr = cmd_write_i;
            case (cmd_code_i)
               pmbst_pkg::CMD_STATUS_SUMMARY: begin
                  known = 1'b1;
                  readonly = 1'b1;
                  next_st.rsp_data = summary; // [R9]
               end
               pmbst_pkg::CMD_OUTPUT_VOLTAGE_STATUS: begin
                  known = 1'b1;
                  next_st.rsp_data = {8'h00, b_vout}; // [R1]
                  flag_clr[8*pmbst_pkg::BYTE_VOUT +: 8] = wr ? cmd_wdata_i[7:0] : 8'h00; // [R11]
               end
               pmbst_pkg::CMD_OUTPUT_CURRENT_STATUS: begin
                  known = 1'b1;
                  next_st.rsp_data = {8'h00, b_iout}; // [R2]
                  flag_clr[8*pmbst_pkg::BYTE_IOUT +: 8] = wr ? cmd_wdata_i[7:0] : 8'h00; // [R11]
               end
               pmbst_pkg::CMD_INPUT_STATUS: begin
                  known = 1'b1;
                  next_st.rsp_data = {8'h00, b_input}; // [R3]
                  flag_clr[8*pmbst_pkg::BYTE_INPUT +: 8] = wr ? cmd_wdata_i[7:0] : 8'h00; // [R11]
               end
               pmbst_pkg::CMD_TEMPERATURE_STATUS: begin
                  known = 1'b1;
                  next_st.rsp_data = {8'h00, b_temp}; // [R4]
                  flag_clr[8*pmbst_pkg::BYTE_TEMP +: 8] = wr ? cmd_wdata_i[7:0] : 8'h00; // [R11]
               end
               pmbst_pkg::CMD_COMMUNICATION_STATUS: begin
                  known = 1'b1;
                  next_st.rsp_data = {8'h00, b_cml}; // [R5]
                  flag_clr[8*pmbst_pkg::BYTE_CML +: 8] = wr ? cmd_wdata_i[7:0] : 8'h00; // [R11]
               end
               pmbst_pkg::CMD_INPUT_VOLTAGE_READING: begin
                  known = 1'b1;
                  readonly = 1'b1;
                  next_st.rsp_data = st.vin; // [R6]
               end
               pmbst_pkg::CMD_OUTPUT_VOLTAGE_READING: begin
                  known = 1'b1;
                  readonly = 1'b1;
                  next_st.rsp_data = st.vout; // [R6]
               end
               pmbst_pkg::CMD_OUTPUT_CURRENT_READING: begin
                  known = 1'b1;
                  readonly = 1'b1;
                  next_st.rsp_data = st.iout; // [R6]
               end
               pmbst_pkg::CMD_TEMPERATURE_READING: begin
                  known = 1'b1;
                  readonly = 1'b1;
                  next_st.rsp_data = st.temp; // [R6]
               end
               pmbst_pkg::CMD_MODULE_TYPE_WORD: begin
                  known = 1'b1;
                  next_st.rsp_data = type_word; // [R7]
                  // Only the write protect bit may change; other bits must match the read value.
                  legal = type_word;
                  legal[pmbst_pkg::TYPE_WPE_BIT] = cmd_wdata_i[pmbst_pkg::TYPE_WPE_BIT];
                  if (wr) begin
                     if (cmd_wdata_i == legal) begin
                        next_st.write_protect_enable = cmd_wdata_i[pmbst_pkg::TYPE_WPE_BIT]; // [R8]
                     end else begin
                        flag_set[8*pmbst_pkg::BYTE_CML + pmbst_pkg::BIT_INVALID_DATA] = 1'b1; // [R5]
                     end
                  end
               end
               default: begin
                  known = 1'b0;
               end
            endcase
            // Unknown codes and writes to read-only words count as unsupported commands.
            if (!known || (wr && readonly)) begin
               flag_set[8*pmbst_pkg::BYTE_CML + pmbst_pkg::BIT_INVALID_CMD] = 1'b1; // [R5]
            end
            // A good read of a known code is answered on the next cycle.
            if (known && !wr) begin
               next_st.rsp_valid = 1'b1;
            end
         end
      end
   end

   // One register process; constants only under reset.
   always_ff @(posedge core_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         st.sync1 <= '0;
         st.sync2 <= '0;
         st.vin <= pmbst_pkg::WORD_RESET;
         st.vout <= pmbst_pkg::WORD_RESET;
         st.iout <= pmbst_pkg::WORD_RESET;
         st.temp <= pmbst_pkg::WORD_RESET;
         st.write_protect_enable <= pmbst_pkg::TYPE_WPE_RESET;
         st.rsp_valid <= 1'b0;
         st.rsp_data <= pmbst_pkg::WORD_RESET;
      end else begin
         st <= next_st;
      end
   end

   assign rsp_valid_o = st.rsp_valid;
   assign rsp_data_o = st.rsp_data;
   assign write_protect_enable_o = st.write_protect_enable; // [R8]
endmodule

//--- pmbst_regs_properties.sv
// Purpose: Port-level assertions for the status and telemetry register bank.
// Assumes: One clock domain with an asynchronous active-low reset.
// Notes: Bound to every instance of the bank; only its ports are watched.
module pmbst_regs_properties #(
   parameter logic [5:0] MODULE_NAME = 6'h15 // Arbitrary value.
) (
   input wire logic core_clk_i,
   input wire logic resetn_i,
   input wire logic cmd_valid_i,
   input wire logic [7:0] cmd_code_i,
   input wire logic cmd_write_i,
   input wire logic [15:0] cmd_wdata_i,
   input wire logic cmd_pec_err_i,
   input wire logic [15:0] vin_meas_i,
   input wire logic rsp_valid_o,
   input wire logic [15:0] rsp_data_o,
   input wire logic write_protect_enable_o
);
   default clocking @(posedge core_clk_i);
   endclocking
   default disable iff (!resetn_i);
   logic rd; // A clean read request.
   logic known; // The code names a register of this bank.
   logic wpe_wr; // A clean write to the type word that keeps its fixed bits.
   logic wpe_req; // Protect bit carried by that write.
   logic [7:0] mask_q; // Supported bits of the status byte last addressed.
   assign rd = cmd_valid_i && !cmd_write_i && !cmd_pec_err_i;
   assign known = cmd_code_i inside {8'h79, [8'h7a:8'h7e], 8'h88, [8'h8b:8'h8d], 8'hd0};
   assign wpe_wr = cmd_valid_i && cmd_write_i && !cmd_pec_err_i && cmd_code_i == 8'hd0
      && cmd_wdata_i[15:8] == 8'h00 && cmd_wdata_i[7:2] == MODULE_NAME && !cmd_wdata_i[0];
   assign wpe_req = cmd_wdata_i[1];
   // Mask is registered so it lines up with the answer one cycle later.
   always_ff @(posedge core_clk_i) begin
      case (cmd_code_i)
         8'h7a: mask_q <= pmbst_pkg::MASK_VOUT;
         8'h7b: mask_q <= pmbst_pkg::MASK_IOUT;
         8'h7c: mask_q <= pmbst_pkg::MASK_INPUT;
         8'h7d: mask_q <= pmbst_pkg::MASK_TEMP;
         default: mask_q <= pmbst_pkg::MASK_CML;
      endcase
   end
   a_read_answer: assert property (rd && known |=> rsp_valid_o)
      else $error("read got no answer");
   a_no_stray: assert property (rsp_valid_o |-> $past(rd))
      else $error("answer without a read");
   a_pec_dropped: assert property (cmd_valid_i && cmd_pec_err_i |=> !rsp_valid_o)
      else $error("command with bad check was answered");
   a_vin_value: assert property (rd && cmd_code_i == 8'h88 && $stable(vin_meas_i)
      && $past(resetn_i, 2) |=> rsp_data_o == $past(vin_meas_i))
      else $error("input voltage reading differs");
   a_type_layout: assert property (rd && cmd_code_i == 8'hd0 |=>
      rsp_data_o == {8'h00, MODULE_NAME, $past(write_protect_enable_o), 1'b0})
      else $error("type word layout wrong");
   a_status_mask: assert property (rd && cmd_code_i inside {[8'h7a:8'h7e]} |=>
      rsp_data_o == {8'h00, rsp_data_o[7:0] & mask_q})
      else $error("unsupported status bit set");
   a_wpe_write: assert property (wpe_wr |=> write_protect_enable_o == $past(wpe_req))
      else $error("protect bit not written");
   a_wpe_steady: assert property (!wpe_wr |=> $stable(write_protect_enable_o))
      else $error("protect bit changed without a valid write");
   c_summary: cover property (rd && cmd_code_i == 8'h79);
   c_wpe: cover property (wpe_wr);
   c_pec: cover property (cmd_valid_i && cmd_pec_err_i);
endmodule
bind pmbst_regs pmbst_regs_properties #(.MODULE_NAME(MODULE_NAME)) u_pmbst_regs_properties (
   .core_clk_i, .resetn_i, .cmd_valid_i, .cmd_code_i, .cmd_write_i, .cmd_wdata_i,
   .cmd_pec_err_i, .vin_meas_i, .rsp_valid_o, .rsp_data_o, .write_protect_enable_o);

//--- pmbst_host.sv
// Purpose: Behavioural host controller that issues commands to the bank.
// Assumes: One-cycle command strobe; reads answer exactly one cycle later.
// Notes: Idle code, write and data lines show the inverse of the last value, never stale data; PEC error idles low.
module pmbst_host (
   input wire logic core_clk_i,
   input wire logic rsp_valid_i,
   input wire logic [15:0] rsp_data_i,
   output logic cmd_valid_o,
   output logic [7:0] cmd_code_o,
   output logic cmd_write_o,
   output logic [15:0] cmd_wdata_o,
   output logic cmd_pec_err_o
);
   timeunit 1ns;
   timeprecision 1ns;
   // Idle values at time zero.
   initial begin
      cmd_valid_o = 1'b0;
      cmd_code_o = 8'h5a;
      cmd_write_o = 1'b0;
      cmd_wdata_o = 16'ha5a5;
      cmd_pec_err_o = 1'b0;
   end
   // One command; a clear writes ones only at the flags to drop.
   task automatic xfer(input logic w, input logic [7:0] c, input logic [15:0] d,
                       input logic p, output logic v, output logic [15:0] q);
      @(negedge core_clk_i);
      cmd_valid_o = 1'b1;
      cmd_code_o = c;
      cmd_write_o = w;
      cmd_wdata_o = d;
      cmd_pec_err_o = p;
      @(negedge core_clk_i);
      // The answer stands only in the cycle after the taking edge, so it is read here,
      // halfway through that cycle, before the request lines are released.
      v = rsp_valid_i;
      q = rsp_data_i;
      cmd_valid_o = 1'b0;
      cmd_code_o = ~c;
      cmd_write_o = ~w;
      cmd_wdata_o = ~d;
      cmd_pec_err_o = 1'b0;
   endtask
endmodule

//--- test_pmbus_status_and_telemetry_regs.sv
// Purpose: Self-checking bench for the status and telemetry register bank.
// Assumes: Inputs change at the falling clock edge; 20 MHz clock.
// Notes: Plain reads run from a table; clears and refusals follow by hand.
module test_pmbus_status_and_telemetry_regs;
   timeunit 1ns;
   timeprecision 1ns;
   typedef struct {logic [7:0] code; logic [15:0] exp;} pmbst_row_t;
   localparam logic [5:0] NAME = 6'h2a; // Arbitrary value.
   logic core_clk_i = 1'b0;
   logic resetn_i = 1'b0;
   logic cmd_valid, cmd_write, cmd_pec, rsp_valid, write_protect_enable, v;
   logic [7:0] cmd_code;
   logic [15:0] cmd_wdata, rsp_data, got;
   logic [7:0] det = 8'h00; // Detector levels, bit 7 is the first detector port.
   logic pg = 1'b1;
   logic off = 1'b0;
   logic [15:0] meas [4] = '{16'h1234, 16'h0bcd, 16'h0019, 16'h0055};
   int err_total = 0;
   int check_count = 0;
   // Every detector flag latched, summary built from them.
   pmbst_row_t rows [10] = '{'{8'h7a, 16'h0080}, '{8'h7b, 16'h00a0}, '{8'h7c, 16'h0098},
      '{8'h7d, 16'h00c0}, '{8'h7e, 16'h0000}, '{8'h88, 16'h1234}, '{8'h8b, 16'h0bcd},
      '{8'h8c, 16'h0019}, '{8'h8d, 16'h0055}, '{8'h79, 16'he03c}};
   always #25 core_clk_i = ~core_clk_i;
   pmbst_regs #(.MODULE_NAME(NAME)) u_pmbst_regs (.core_clk_i(core_clk_i),
      .resetn_i(resetn_i), .cmd_valid_i(cmd_valid), .cmd_code_i(cmd_code),
      .cmd_write_i(cmd_write), .cmd_wdata_i(cmd_wdata), .cmd_pec_err_i(cmd_pec),
      .vout_ov_fault_i(det[7]), .iout_oc_fault_i(det[6]), .iout_oc_warn_i(det[5]),
      .vin_ov_fault_i(det[4]), .vin_uv_fault_i(det[3]), .unit_off_low_vin_i(det[2]),
      .ot_fault_i(det[1]), .ot_warn_i(det[0]), .power_good_i(pg), .output_off_i(off),
      .vin_meas_i(meas[0]), .vout_meas_i(meas[1]), .iout_meas_i(meas[2]),
      .temp_meas_i(meas[3]), .rsp_valid_o(rsp_valid), .rsp_data_o(rsp_data),
      .write_protect_enable_o(write_protect_enable));
   pmbst_host u_pmbst_host (.core_clk_i(core_clk_i), .rsp_valid_i(rsp_valid),
      .rsp_data_i(rsp_data), .cmd_valid_o(cmd_valid), .cmd_code_o(cmd_code),
      .cmd_write_o(cmd_write), .cmd_wdata_o(cmd_wdata), .cmd_pec_err_o(cmd_pec));
   // Compare and count; an unknown never matches.
   task automatic chk(input logic [15:0] g, input logic [15:0] e);
      check_count++;
      if (g !== e) begin
         err_total++;
         $display("mismatch at %0t: got %h want %h", $time, g, e);
      end
   endtask
   // A read must answer with the expected word.
   task automatic rd(input logic [7:0] c, input logic [15:0] e);
      u_pmbst_host.xfer(1'b0, c, 16'h0000, 1'b0, v, got);
      chk({15'h0000, v}, 16'h0001);
      chk(got, e);
   endtask
   // A command that must draw no answer.
   task automatic quiet(input logic w, input logic [7:0] c, input logic [15:0] d, input logic p);
      u_pmbst_host.xfer(w, c, d, p, v, got);
      chk({15'h0000, v}, 16'h0000);
   endtask
   task automatic print_verdict();
      if (err_total == 0 && check_count > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask
   // Main sequence; detector pulses last four cycles to cover the sync delay.
   initial begin
      repeat (10) @(negedge core_clk_i);
      resetn_i = 1'b1;
      chk({15'h0000, write_protect_enable}, 16'h0001);
      rd(8'hd0, {8'h00, NAME, 2'b10});
      rd(8'h7c, 16'h0000);
      det = 8'hff;
      repeat (4) @(negedge core_clk_i);
      det = 8'h00;
      repeat (4) @(negedge core_clk_i);
      foreach (rows[i]) rd(rows[i].code, rows[i].exp);
      quiet(1'b1, 8'h7c, 16'h0010, 1'b0);
      rd(8'h7c, 16'h0088);
      quiet(1'b1, 8'h7a, 16'h0000, 1'b0);
      rd(8'h7a, 16'h0080);
      quiet(1'b1, 8'h7a, 16'h00ff, 1'b0);
      rd(8'h7a, 16'h0000);
      // A detector still high wins over the clear, so the flag survives.
      det = 8'h01;
      repeat (4) @(negedge core_clk_i);
      quiet(1'b1, 8'h7d, 16'h00ff, 1'b0);
      rd(8'h7d, 16'h0040);
      det = 8'h00;
      quiet(1'b1, 8'h88, 16'h0000, 1'b0);
      rd(8'h7e, 16'h0080);
      quiet(1'b0, 8'h7a, 16'h0000, 1'b1);
      quiet(1'b1, 8'hd0, {8'h01, NAME, 2'b00}, 1'b0);
      chk({15'h0000, write_protect_enable}, 16'h0001);
      rd(8'h7e, 16'h00e0);
      quiet(1'b1, 8'h7e, 16'h00ff, 1'b0);
      quiet(1'b0, 8'h55, 16'h0000, 1'b0);
      rd(8'h7e, 16'h0080);
      quiet(1'b1, 8'hd0, {8'h00, NAME, 2'b00}, 1'b0);
      chk({15'h0000, write_protect_enable}, 16'h0000);
      rd(8'hd0, {8'h00, NAME, 2'b00});
      // A new measurement must show in the next reading.
      meas[0] = 16'h2345;
      rd(8'h88, 16'h2345);
      // Power lost and output off must reach the summary through their synchronisers.
      pg = 1'b0;
      off = 1'b1;
      repeat (4) @(negedge core_clk_i);
      rd(8'h79, 16'h6856);
      // A second reset in mid-run must restore protection and drop the flags.
      resetn_i = 1'b0;
      repeat (2) @(negedge core_clk_i);
      resetn_i = 1'b1;
      chk({15'h0000, write_protect_enable}, 16'h0001);
      rd(8'h7d, 16'h0000);
      print_verdict();
   end
endmodule
